//--- tcp_pins.sv
`timescale 1ns/1ps
// ============================================================
// pin-side environment: external count clock and capture trigger
module tcp_pins (
   input  wire logic clk_in,          // system clock
   output logic      count_clock_out, // external count clock pin
   output logic      capture_out      // capture trigger pin
);
   initial begin
      count_clock_out = 1'b0;
      capture_out     = 1'b0;
   end

   // ============================================================
   // levels held 3 clocks, above the 2-clock minimum
   task automatic pulse_clk(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_in);
         count_clock_out <= 1'b1;
         repeat (3) @(posedge clk_in);
         count_clock_out <= 1'b0;
         repeat (2) @(posedge clk_in);
      end
   endtask

   task automatic pulse_cap();
      @(posedge clk_in);
      capture_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      capture_out <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask
endmodule

//--- tcp_pkg.sv
// ============================================================
// timer/counter shared definitions
package tcp_pkg;

   localparam int CNT_W  = 16;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;

   // ============================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_TOP  = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_CMP  = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_CNT  = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_CAP  = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_STAT = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_MASK = 5'h18;
   localparam logic [ADDR_W-1:0] OFS_PEND = 5'h1c;

   // ============================================================
   // interrupt bit layout (status, mask, pending)
   localparam int IRQ_W   = 3;
   localparam int IRQ_OVF = 0;
   localparam int IRQ_CMP = 1;
   localparam int IRQ_CAP = 2;
   localparam logic [IRQ_W-1:0] IRQ_OVF_ONLY = 3'h1;

   // ============================================================
   // modes and control word
   typedef enum logic [1:0] {
      MODE_WDOG,
      MODE_CTC,
      MODE_FAST,
      MODE_PFC
   } tcp_mode_e;

   typedef logic [2:0] tcp_presc_t;

   // bit 8 rst_en, 7 cap_en, 6:4 presc, 3 clk_ext, 2:1 mode, 0 run
   typedef struct packed {
      logic       rst_en;
      logic       cap_en;
      tcp_presc_t presc;
      logic       clk_ext;
      tcp_mode_e  mode;
      logic       run;
   } tcp_ctrl_s;

   localparam int CTRL_W = 9;
   localparam tcp_ctrl_s CTRL_RST = '0;

   // ============================================================
   // prescaler terminal counts (divide by 1, 8, 64, 256, 1024)
   localparam int PRE_W = 10;
   localparam logic [PRE_W-1:0] PRE_LIM_1    = 10'h000;
   localparam logic [PRE_W-1:0] PRE_LIM_8    = 10'h007;
   localparam logic [PRE_W-1:0] PRE_LIM_64   = 10'h03f;
   localparam logic [PRE_W-1:0] PRE_LIM_256  = 10'h0ff;
   localparam logic [PRE_W-1:0] PRE_LIM_1024 = 10'h3ff;

   function automatic logic [PRE_W-1:0] tcp_pre_lim(input tcp_presc_t code);
      logic [PRE_W-1:0] lim;
      lim = PRE_LIM_1;
      case (code)
         3'h1:    lim = PRE_LIM_8;
         3'h2:    lim = PRE_LIM_64;
         3'h3:    lim = PRE_LIM_256;
         3'h4:    lim = PRE_LIM_1024;
         default: lim = PRE_LIM_1;
      endcase
      return lim;
   endfunction

endpackage

//--- tcp_sync.sv
`timescale 1ns/1ps
// ============================================================
// two-stage synchroniser for asynchronous pins
module tcp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,   // system clock
   input  wire logic         rstn_in,  // async reset, active low
   input  wire logic [W-1:0] d_in,     // asynchronous inputs
   output logic      [W-1:0] q_out     // synchronised outputs
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   if (W < 1) begin : g_chk
      $error("tcp_sync width must be at least one");
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;
endmodule

//--- tcp_timer.sv
`timescale 1ns/1ps
// Summary of operation
// - 16-bit up/down counter feeding a compare unit with PWM output
// - modes: watchdog, clear on compare match, fast PWM, phase-frequency PWM
// - count source selectable, then divided by a programmable prescaler
// - overflow, compare match and capture reported as separate flags
// - capture edge in non-PWM bus mode stores the count as a time-stamp
// - stand-alone irq is overflow flag; bus mode uses status, mask, pending
// - one level interrupt to routing plus a separate wake-up pulse
// - PWM output glitch-free, period and duty updated only at period end
// - stand-alone preloads control and keeps the counter reset pin enabled
// - registers reached over the bus and the block answers there
module tcp_timer
   import tcp_pkg::*;
#(
   parameter int               CNT_W   = tcp_pkg::CNT_W,
   parameter tcp_pkg::tcp_ctrl_s SA_CTRL = tcp_pkg::CTRL_RST,
   parameter logic [15:0]      SA_TOP  = 16'hffff,
   parameter logic [15:0]      SA_CMP  = 16'h8000
) (
   input  wire logic                        clk_in,             // system clock
   input  wire logic                        rstn_in,            // async reset, active low
   input  wire logic [tcp_pkg::ADDR_W-1:0]  avs_address_in,     // byte address
   input  wire logic                        avs_read_in,        // read request
   input  wire logic                        avs_write_in,       // write request
   input  wire logic [tcp_pkg::DATA_W-1:0]  avs_writedata_in,   // write data
   input  wire logic [tcp_pkg::BE_W-1:0]    avs_byteenable_in,  // byte enables
   output logic      [tcp_pkg::DATA_W-1:0]  avs_readdata_out,   // read data
   output logic                             avs_waitrequest_out,// stall
   input  wire logic                        standalone_in,      // strap, no bus use
   input  wire logic                        count_clock_in,     // external count clock pin
   input  wire logic                        counter_reset_n_in, // counter reset pin
   input  wire logic                        capture_trigger_in, // capture trigger pin
   output logic                             waveform_out,       // compare/PWM output
   output logic                             counter_irq_out,    // level interrupt
   output logic                             wake_irq_out        // wake-up pulse
);
   import tcp_pkg::*;

   if (CNT_W < 2 || CNT_W > 16) begin : g_chk
      $error("tcp_timer counter width must be 2 to 16");
   end

   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
   localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   // ============================================================
   // pin synchronisers
   logic [2:0] pins_s;
   logic       cclk_s;
   logic       crst_s;
   logic       trig_s;

   tcp_sync #(.W(3)) u_sync (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .d_in    ({count_clock_in, !counter_reset_n_in, capture_trigger_in}),
      .q_out   (pins_s)
   );

   assign cclk_s  = pins_s[2];
   assign crst_s  = pins_s[1]; // inverted pin, so flop reset value is idle
   assign trig_s  = pins_s[0];

   // ============================================================
   // bus and configuration state
   logic                wait_q, wait_d;
   logic [DATA_W-1:0]   rdata_q, rdata_d;
   tcp_ctrl_s           ctrl_q, ctrl_d;
   logic [CNT_W-1:0]    top_q, top_d;
   logic [CNT_W-1:0]    cmp_q, cmp_d;
   logic [IRQ_W-1:0]    mask_q, mask_d;
   logic                sa_q, sa_d;
   logic                strap_q, strap_d;
   logic [DATA_W-1:0]   rd_mux;
   logic [DATA_W-1:0]   wr_merged;
   logic                acc;
   logic                wr_en;
   logic                rd_en;
   logic                cnt_wr;
   logic                stat_rd;

   // counter state
   logic [CNT_W-1:0]    cnt_q, cnt_d;
   logic [PRE_W-1:0]    pre_q, pre_d;
   logic                dir_q, dir_d;
   logic [CNT_W-1:0]    atop_q, atop_d;
   logic [CNT_W-1:0]    acmp_q, acmp_d;
   logic                wave_q, wave_d;
   logic [CNT_W-1:0]    cap_q, cap_d;
   logic [IRQ_W-1:0]    status_q, status_d;
   logic                irq_q, irq_d;
   logic                wake_q, wake_d;
   logic                cclk_prev_q;
   logic                trig_prev_q;
   logic [IRQ_W-1:0]    ev;
   logic                tick;
   logic                pwm;
   logic                crst_act;

   function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] nw,
                                                  input logic [BE_W-1:0]   be);
      logic [DATA_W-1:0] r;
      r = old;
      for (int i = 0; i < BE_W; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // a request is taken on the edge where waitrequest is seen low
   assign acc     = (avs_read_in || avs_write_in) && !wait_q;
   assign wr_en   = acc && avs_write_in && !sa_q;
   assign rd_en   = acc && avs_read_in;
   assign cnt_wr  = wr_en && (avs_address_in == OFS_CNT);
   assign stat_rd = rd_en && (avs_address_in == OFS_STAT);

   // ============================================================
   // register readback
   always_comb begin
      rd_mux = '0;
      case (avs_address_in)
         OFS_CTRL: rd_mux[CTRL_W-1:0] = ctrl_q;
         OFS_TOP:  rd_mux[CNT_W-1:0]  = top_q;
         OFS_CMP:  rd_mux[CNT_W-1:0]  = cmp_q;
         OFS_CNT:  rd_mux[CNT_W-1:0]  = cnt_q;
         OFS_CAP:  rd_mux[CNT_W-1:0]  = cap_q;
         OFS_STAT: rd_mux[IRQ_W-1:0]  = status_q;
         OFS_MASK: rd_mux[IRQ_W-1:0]  = mask_q;
         OFS_PEND: rd_mux[IRQ_W-1:0]  = status_q & mask_q;
         default:  rd_mux = '0;
      endcase
   end

   assign wr_merged = be_merge(rd_mux, avs_writedata_in, avs_byteenable_in);

   // ============================================================
   // bus slave and configuration registers
   always_comb begin
      wait_d  = wait_q;
      rdata_d = rdata_q;
      ctrl_d  = ctrl_q;
      top_d   = top_q;
      cmp_d   = cmp_q;
      mask_d  = mask_q;
      sa_d    = sa_q;
      strap_d = 1'b1;
      if (!strap_q) begin
         sa_d = standalone_in;
      end
      if (wait_q && (avs_read_in || avs_write_in)) begin
         wait_d  = 1'b0;
         rdata_d = rd_mux;
      end else if (!wait_q) begin
         wait_d = 1'b1;
      end
      if (wr_en) begin
         case (avs_address_in)
            OFS_CTRL: ctrl_d = tcp_ctrl_s'(wr_merged[CTRL_W-1:0]);
            OFS_TOP:  top_d  = wr_merged[CNT_W-1:0];
            OFS_CMP:  cmp_d  = wr_merged[CNT_W-1:0];
            OFS_MASK: mask_d = wr_merged[IRQ_W-1:0];
            default:  ;
         endcase
      end
      if (sa_q) begin
         ctrl_d        = SA_CTRL;
         ctrl_d.rst_en = 1'b1;
         top_d         = SA_TOP[CNT_W-1:0];
         cmp_d         = SA_CMP[CNT_W-1:0];
         mask_d        = IRQ_OVF_ONLY;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wait_q  <= 1'b1;
         rdata_q <= '0;
         ctrl_q  <= CTRL_RST;
         top_q   <= CNT_MAX;
         cmp_q   <= '0;
         mask_q  <= '0;
         sa_q    <= 1'b0;
         strap_q <= 1'b0;
      end else begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         ctrl_q  <= ctrl_d;
         top_q   <= top_d;
         cmp_q   <= cmp_d;
         mask_q  <= mask_d;
         sa_q    <= sa_d;
         strap_q <= strap_d;
      end
   end

   // ============================================================
   // prescaler, counter, compare, capture, flags
   assign pwm      = (ctrl_q.mode == MODE_FAST) || (ctrl_q.mode == MODE_PFC);
   assign crst_act = ctrl_q.rst_en && crst_s;

   always_comb begin
      logic src;
      src      = ctrl_q.clk_ext ? (cclk_s && !cclk_prev_q) : 1'b1;
      tick     = 1'b0;
      pre_d    = pre_q;
      cnt_d    = cnt_q;
      dir_d    = dir_q;
      atop_d   = atop_q;
      acmp_d   = acmp_q;
      wave_d   = wave_q;
      cap_d    = cap_q;
      ev       = '0;
      status_d = status_q;
      if (ctrl_q.run && src) begin
         if (pre_q >= tcp_pre_lim(ctrl_q.presc)) begin
            pre_d = '0;
            tick  = 1'b1;
         end else begin
            pre_d = pre_q + 1'b1;
         end
      end
      if (!pwm) begin
         atop_d = top_q;
         acmp_d = cmp_q;
      end
      if (tick) begin
         ev[IRQ_CMP] = (cnt_q == acmp_q);
         unique case (ctrl_q.mode)
            MODE_WDOG: begin
               cnt_d        = cnt_q + CNT_ONE;
               ev[IRQ_OVF]  = (cnt_q == CNT_MAX);
            end
            MODE_CTC, MODE_FAST: begin
               if (cnt_q >= atop_q) begin
                  cnt_d       = '0;
                  ev[IRQ_OVF] = 1'b1;
               end else begin
                  cnt_d = cnt_q + CNT_ONE;
               end
            end
            MODE_PFC: begin
               if (!dir_q) begin
                  if (cnt_q >= atop_q) begin
                     dir_d = 1'b1;
                     cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - CNT_ONE;
                  end else begin
                     cnt_d = cnt_q + CNT_ONE;
                  end
               end else if (cnt_q == '0) begin
                  dir_d       = 1'b0;
                  cnt_d       = (atop_q == '0) ? cnt_q : CNT_ONE;
                  ev[IRQ_OVF] = 1'b1;
               end else begin
                  cnt_d = cnt_q - CNT_ONE;
               end
            end
         endcase
         if (pwm && ev[IRQ_OVF]) begin
            atop_d = top_q;
            acmp_d = cmp_q;
         end
         if (!pwm && ev[IRQ_CMP]) begin
            wave_d = !wave_q;
         end
      end
      if (cnt_wr) begin
         cnt_d = wr_merged[CNT_W-1:0];
         pre_d = '0;
      end
      if (crst_act) begin
         cnt_d  = '0;
         dir_d  = 1'b0;
         pre_d  = '0;
         wave_d = 1'b0;
      end
      if (ctrl_q.cap_en && !pwm && !sa_q && trig_s && !trig_prev_q) begin
         cap_d       = cnt_q;
         ev[IRQ_CAP] = 1'b1;
      end
      if (pwm) begin
         wave_d = (cnt_d < acmp_d);
      end
      if (stat_rd) begin
         status_d = status_q & ~rdata_q[IRQ_W-1:0];
      end
      if (sa_q && crst_act) begin
         status_d = '0;
      end
      status_d = status_d | ev;
      irq_d    = sa_d ? status_d[IRQ_OVF] : |(status_d & mask_d);
      wake_d   = |(ev & (sa_q ? IRQ_OVF_ONLY : mask_q));
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pre_q       <= '0;
         cnt_q       <= '0;
         dir_q       <= 1'b0;
         atop_q      <= CNT_MAX;
         acmp_q      <= '0;
         wave_q      <= 1'b0;
         cap_q       <= '0;
         status_q    <= '0;
         irq_q       <= 1'b0;
         wake_q      <= 1'b0;
         cclk_prev_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         pre_q       <= pre_d;
         cnt_q       <= cnt_d;
         dir_q       <= dir_d;
         atop_q      <= atop_d;
         acmp_q      <= acmp_d;
         wave_q      <= wave_d;
         cap_q       <= cap_d;
         status_q    <= status_d;
         irq_q       <= irq_d;
         wake_q      <= wake_d;
         cclk_prev_q <= cclk_s;
         trig_prev_q <= trig_s;
      end
   end

   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign waveform_out        = wave_q;
   assign counter_irq_out     = irq_q;
   assign wake_irq_out        = wake_q;

   // ============================================================
   // assertions
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_req_seen;
      (avs_read_in || avs_write_in) && wait_q;
   endsequence
   sequence s_ack_pulse;
      !wait_q ##1 wait_q;
   endsequence

   property p_bus_ack;
      s_req_seen |=> s_ack_pulse;
   endproperty
   a_bus_ack: assert property (p_bus_ack)
      else $error("waitrequest did not drop for exactly one cycle");

   property p_wdog_step;
      tick && ctrl_q.mode == MODE_WDOG && !crst_act && !cnt_wr
         |=> cnt_q == CNT_W'($past(cnt_q) + CNT_ONE);
   endproperty
   a_wdog_step: assert property (p_wdog_step)
      else $error("counter did not advance by one");

   property p_ctc_clear;
      tick && ctrl_q.mode == MODE_CTC && cnt_q >= atop_q && !crst_act && !cnt_wr
         |=> cnt_q == '0;
   endproperty
   a_ctc_clear: assert property (p_ctc_clear)
      else $error("counter not cleared at period end");

   property p_presc_gap;
      tick && tcp_pre_lim(ctrl_q.presc) != PRE_LIM_1 ##1 $stable(ctrl_q.presc) |-> !tick;
   endproperty
   a_presc_gap: assert property (p_presc_gap)
      else $error("prescaler ticked on consecutive cycles");

   property p_cmp_flag;
      ev[IRQ_CMP] |=> status_q[IRQ_CMP];
   endproperty
   a_cmp_flag: assert property (p_cmp_flag)
      else $error("compare flag not set");

   property p_cap_stamp;
      ev[IRQ_CAP] |=> cap_q == $past(cnt_q) && status_q[IRQ_CAP];
   endproperty
   a_cap_stamp: assert property (p_cap_stamp)
      else $error("capture did not store the count");

   property p_irq_level;
      irq_q == (sa_q ? status_q[IRQ_OVF] : |(status_q & mask_q));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt level disagrees with flags");

   property p_wake;
      !sa_q && |(ev & mask_q) |=> wake_irq_out ##1 (wake_irq_out == $past(|(ev & mask_q)));
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake-up pulse missing");

   property p_pwm_wave;
      $past(pwm) |-> wave_q == (cnt_q < acmp_q);
   endproperty
   a_pwm_wave: assert property (p_pwm_wave)
      else $error("pwm output does not follow compare");

   property p_sa_rst;
      sa_q ##1 sa_q |-> ctrl_q.rst_en;
   endproperty
   a_sa_rst: assert property (p_sa_rst)
      else $error("reset pin not enabled in stand-alone");

   property p_reload;
      pwm && ev[IRQ_OVF] |=> atop_q == $past(top_q) && acmp_q == $past(cmp_q);
   endproperty
   a_reload: assert property (p_reload)
      else $error("period values not reloaded at period end");

   property p_cap_once;
      ev[IRQ_CAP] |=> !ev[IRQ_CAP];
   endproperty
   a_cap_once: assert property (p_cap_once)
      else $error("capture taken twice for one edge");

   property p_ovf_hold;
      status_q[IRQ_OVF] && !stat_rd && !(sa_q && crst_act) |=> status_q[IRQ_OVF];
   endproperty
   a_ovf_hold: assert property (p_ovf_hold)
      else $error("overflow flag dropped without a clear");
endmodule

//--- tcp_timer_tb.sv
`timescale 1ns/1ps
module tcp_timer_tb;
   import tcp_pkg::*;
   logic                clk_in   = 1'b0;
   logic                rstn_in  = 1'b0;
   logic [ADDR_W-1:0]   addr     = '0;
   logic                rd       = 1'b0;
   logic                wr       = 1'b0;
   logic [DATA_W-1:0]   wdata    = '0;
   logic [BE_W-1:0]     ben      = '0;
   logic                crst_n   = 1'b1;
   logic                sa       = 1'b0;
   logic [DATA_W-1:0]   rdata;
   logic                wait_rq;
   logic                wave;
   logic                irq;
   logic                wake;
   logic                cclk;
   logic                cap;
   logic [DATA_W-1:0]   v;
   int                  failures = 0;
   int                  checks   = 0;
   int                  hi;

   always #50 clk_in = ~clk_in;

   // stand-alone preload: running ctc, reset pin enable left to the forcing
   localparam tcp_ctrl_s SA_C = '{1'b0, 1'b0, 3'h0, 1'b0, MODE_CTC, 1'b1};

   tcp_timer #(.SA_CTRL(SA_C), .SA_TOP(16'h0007)) u_tcp_timer (
      .clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(ben),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq), .standalone_in(sa),
      .count_clock_in(cclk), .counter_reset_n_in(crst_n), .capture_trigger_in(cap),
      .waveform_out(wave), .counter_irq_out(irq), .wake_irq_out(wake));

   tcp_pins u_tcp_pins (.clk_in(clk_in), .count_clock_out(cclk), .capture_out(cap));

   task automatic give_verdict();
      if (failures == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ============================================================
   // bus cycle: hold request until waitrequest sampled low
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [BE_W-1:0] b);
      int n;
      n = 0;
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      ben   <= b;
      wr    <= w;
      rd    <= ~w;
      do begin
         @(posedge clk_in);
         n++;
      end while (wait_rq !== 1'b0 && n < 20);
      v = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 20) begin
         failures++;
         give_verdict();
      end
   endtask

   task automatic wr32(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      bus(1'b0, a, '0, 4'hf);
      chk(v, e);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
         @(posedge clk_in);
         n++;
      end
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, wake}, 32'h1);
      if (n >= 300) begin
         give_verdict();
      end
   endtask

   task automatic count_hi(input int n);
      hi = 0;
      repeat (n) begin
         @(posedge clk_in);
         hi += (wave === 1'b1) ? 1 : 0;
      end
   endtask

   function automatic logic [DATA_W-1:0] ctl(tcp_mode_e m, logic run, logic ext,
                                             logic cap_en, logic rst_en);
      tcp_ctrl_s c;
      c = '{rst_en, cap_en, 3'h0, ext, m, run};
      return DATA_W'(c);
   endfunction

   localparam logic [ADDR_W-1:0] RA [8] = '{OFS_CTRL, OFS_TOP, OFS_CMP, OFS_CNT,
                                            OFS_CAP, OFS_STAT, OFS_MASK, OFS_PEND};
   localparam logic [DATA_W-1:0] RV [8] = '{32'h0, 32'hffff, 32'h0, 32'h0,
                                            32'h0, 32'h0, 32'h0, 32'h0};

   initial begin
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      for (int i = 0; i < 8; i++) rd_chk(RA[i], RV[i]);
      rd_chk(5'h02, 32'h0);
      bus(1'b1, OFS_TOP, 32'h00ab, 4'h1);
      rd_chk(OFS_TOP, 32'hffab);
      wr32(OFS_CAP, 32'h77);
      rd_chk(OFS_CAP, 32'h0);
      // ============================================================
      // overflow flag and clear on read in every mode
      wr32(OFS_MASK, 32'h1);
      wr32(OFS_TOP, 32'h5);
      for (int m = 0; m < 4; m++) begin
         wr32(OFS_CNT, (m == 0) ? 32'hfff0 : 32'h0);
         wr32(OFS_CTRL, ctl(tcp_mode_e'(m), 1'b1, 1'b0, 1'b0, 1'b0));
         wait_irq();
         wr32(OFS_CTRL, 32'h0);
         bus(1'b0, OFS_STAT, '0, 4'hf);
         chk(v & 32'h1, 32'h1);
         rd_chk(OFS_STAT, 32'h0);
         repeat (2) @(posedge clk_in);
         chk({31'h0, irq}, 32'h0);
      end
      // ============================================================
      // compare flag, pending view, masking
      wr32(OFS_MASK, 32'h2);
      wr32(OFS_CMP, 32'h3);
      wr32(OFS_CTRL, ctl(MODE_CTC, 1'b1, 1'b0, 1'b0, 1'b0));
      wait_irq();
      wr32(OFS_CTRL, 32'h0);
      rd_chk(OFS_PEND, 32'h2);
      bus(1'b0, OFS_STAT, '0, 4'hf);
      chk(v & 32'h3, 32'h3);
      wr32(OFS_MASK, 32'h0);
      wr32(OFS_CTRL, ctl(MODE_CTC, 1'b1, 1'b0, 1'b0, 1'b0));
      repeat (40) @(posedge clk_in);
      chk({31'h0, irq}, 32'h0);
      wr32(OFS_CTRL, 32'h0);
      bus(1'b0, OFS_STAT, '0, 4'hf);
      // ============================================================
      // capture accepted in watchdog, refused in fast pwm
      wr32(OFS_MASK, 32'h4);
      wr32(OFS_CNT, 32'h1234);
      wr32(OFS_CTRL, ctl(MODE_WDOG, 1'b0, 1'b0, 1'b1, 1'b0));
      u_tcp_pins.pulse_cap();
      repeat (6) @(posedge clk_in);
      rd_chk(OFS_CAP, 32'h1234);
      chk({31'h0, irq}, 32'h1);
      rd_chk(OFS_STAT, 32'h4);
      wr32(OFS_CNT, 32'h0042);
      wr32(OFS_CTRL, ctl(MODE_FAST, 1'b0, 1'b0, 1'b1, 1'b0));
      u_tcp_pins.pulse_cap();
      repeat (6) @(posedge clk_in);
      rd_chk(OFS_CAP, 32'h1234);
      // ============================================================
      // external count clock
      wr32(OFS_CTRL, 32'h0);
      wr32(OFS_CNT, 32'h0);
      wr32(OFS_CTRL, ctl(MODE_WDOG, 1'b1, 1'b1, 1'b0, 1'b0));
      u_tcp_pins.pulse_clk(5);
      repeat (6) @(posedge clk_in);
      wr32(OFS_CTRL, 32'h0);
      rd_chk(OFS_CNT, 32'h5);
      // divide by 8: ticks at 8, 16 .. 80 cycles after the start
      wr32(OFS_CNT, 32'h0);
      wr32(OFS_CTRL, ctl(MODE_WDOG, 1'b1, 1'b0, 1'b0, 1'b0) | 32'h10);
      repeat (80) @(posedge clk_in);
      wr32(OFS_CTRL, 32'h0);
      rd_chk(OFS_CNT, 32'ha);
      // ============================================================
      // fast pwm duty, then period change while running
      wr32(OFS_TOP, 32'h9);
      wr32(OFS_CMP, 32'h4);
      wr32(OFS_CNT, 32'h0);
      wr32(OFS_CTRL, ctl(MODE_FAST, 1'b1, 1'b0, 1'b0, 1'b0));
      repeat (25) @(posedge clk_in);
      count_hi(30);
      chk(32'(hi), 32'd12);
      wr32(OFS_TOP, 32'h13);
      repeat (45) @(posedge clk_in);
      count_hi(40);
      chk(32'(hi), 32'd8);
      // ============================================================
      // counter reset pin
      wr32(OFS_CTRL, ctl(MODE_WDOG, 1'b0, 1'b0, 1'b0, 1'b1));
      wr32(OFS_CNT, 32'h55);
      crst_n <= 1'b0;
      repeat (5) @(posedge clk_in);
      crst_n <= 1'b1;
      rd_chk(OFS_CNT, 32'h0);
      // ============================================================
      // stand-alone after a second reset
      rstn_in <= 1'b0;
      sa      <= 1'b1;
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      rd_chk(OFS_CTRL, 32'h103);
      wr32(OFS_CTRL, 32'h0);
      rd_chk(OFS_CTRL, 32'h103);
      repeat (10) @(posedge clk_in);
      chk({31'h0, irq}, 32'h1);
      crst_n <= 1'b0;
      repeat (5) @(posedge clk_in);
      chk({31'h0, irq}, 32'h0);
      give_verdict();
   end
endmodule
